// *** include/pecfg_pkg.sv ***
/*
  shared constants and types of the event interrupt and configuration block.
  assumes a 32-bit ahb-lite bus and a single core clock.
*/
// How it works
// - interrupt pin only for events enabled in mask and master control
// - status bit sets on every event, enabled or not
// - latched status bit holds until status read, read clears it
// - mask holds sixteen read-write enables, reset zero, same bit positions
// - latched clear-on-read bits: 15-10, 8-4, 1 and 0
// - bits 9, 3, 2 read-only; bit 1 latches high
// - config bit 13 picks pin polarity, 1 is active low, reset 1
// - writing 1 to config bit 12 gives one reset pulse, bit self-clears
// - bits 11-10 pick failed attempts before downshift: 1,2,4,8; reset 2
// - bit 9 enables downshift, reset 0
// - bit 8 enables energy-based downshift on pairs c and d, reset 1
// - bit 6 allows further downshift to ten megabit, reset 1
// - bit 7 enables serial mac auto-negotiation, reset 1
// - bit 14 suppresses serial mac transmit error indication, reset 0
// - bit 15 enables powered-device probe, hardware may update it
// - bits 5-4 pick transmit clock: 2.5 MHz, 25 MHz, else off
// - bit 3 enables collision output in full duplex, reset 0
// - bit 2 allows automatic old scrambler selection, reset 1
// - bits 1 and 0 enable semi-cross as master and slave, reset 1
package pecfg_pkg;
  localparam int REG_W = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MASK = 8'h12;
  localparam logic [7:0] IDX_STATUS = 8'h13;
  localparam logic [7:0] IDX_CFG = 8'h14;
  localparam logic [7:0] IDX_MASTER = 8'h20;
  // reset values
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h29C7;
  localparam logic [15:0] MASTER_RST = 16'h0000;
  // status bit classes
  localparam logic [15:0] LATCH_BITS = 16'hFDF3;
  localparam logic [15:0] LIVE_BITS = 16'h020C;
  // field positions
  localparam int MASTER_EN_POS = 0;
  localparam int CFG_SRST_POS = 12;
  localparam int CFG_PD_POS = 15;
  // transmit clock choices
  localparam logic [1:0] TXCLK_SLOW = 2'h0;
  localparam logic [1:0] TXCLK_FAST = 2'h1;

  // general configuration, msb first
  typedef struct packed {
    logic poweredDeviceProbeEnable;
    logic serialMacTxErrorOff;
    logic intActiveLow;
    logic serialMacSoftReset;
    logic [1:0] downshiftTryCount;
    logic downshiftEnable;
    logic downshiftEnergyMode;
    logic serialMacNegotiationOn;
    logic downshiftToTenEnable;
    logic [1:0] txClockSelect;
    logic fullDuplexCollisionOut;
    logic oldScramblerAutoSelect;
    logic masterSemiCross;
    logic slaveSemiCross;
  } pecfg_cfg_t;

  // one register access from the bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [15:0] wdata;
  } pecfg_req_t;
endpackage : pecfg_pkg

// *** rtl/pecfg_ahb_slave.sv ***
/*
  ahb-lite slave front end: writes zero wait, reads one wait state.
  assumes it is the only slave, so hready is its own hreadyout.
*/
`timescale 1ns/1ps
module pecfg_ahb_slave import pecfg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // register side
  output pecfg_req_t req,
  input wire logic [15:0] rdData
);
  logic phWr_r;
  logic phRd_r;
  logic [7:0] phIdx_r;
  logic readyOut_r;
  logic [31:0] rdata_r;
  wire accept = hsel & htrans[1] & hready;
  wire rdStrobe = phRd_r & ~readyOut_r;

  // access strobes toward the register file
  assign req.wr = phWr_r & hready;
  assign req.rd = rdStrobe;
  assign req.idx = phIdx_r;
  assign req.wdata = hwdata[15:0];

  // address phase capture and read wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phWr_r <= 1'b0;
      phRd_r <= 1'b0;
      phIdx_r <= 8'h00;
      readyOut_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      if (hready) begin
        phWr_r <= accept & hwrite;
        phRd_r <= accept & ~hwrite;
        phIdx_r <= haddr[9:2];
        readyOut_r <= ~(accept & ~hwrite);
      end
      if (rdStrobe) begin
        rdata_r <= {16'h0000, rdData};
        readyOut_r <= 1'b1;
      end
    end
  end

  assign hreadyout = readyOut_r;
  assign hrdata = rdata_r;
  assign hresp = 1'b0; // always okay
endmodule : pecfg_ahb_slave

// *** rtl/pecfg_top.sv ***
/*
  event interrupt mask, latched event status and general configuration.
  assumes event sources run on clk and drive eventIn without crossing.
*/
`timescale 1ns/1ps
module pecfg_top import pecfg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // event sources
  input wire logic [15:0] eventIn,
  input wire logic pdProbeDone,
  // interrupt pin and configuration outputs
  output logic intPin,
  output pecfg_cfg_t cfgOut,
  output logic serialMacReset,
  output logic [3:0] downshiftTries,
  output logic txClockOn
);
  pecfg_req_t req;
  logic [15:0] rdData;
  logic [15:0] mask_r;
  logic [15:0] mask_nxt;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] master_r;
  logic [15:0] master_nxt;
  pecfg_cfg_t cfg_r;
  pecfg_cfg_t cfg_nxt;
  pecfg_cfg_t cfgWr;
  logic intPin_r;
  logic srst_r;
  logic [3:0] tries_r;
  logic txOn_r;
  logic unusedSize;

  // bus front end
  pecfg_ahb_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .req(req),
    .rdData(rdData)
  );

  // only whole-word transfers are used
  assign unusedSize = ^hsize;

  // register decode
  wire wrMask = req.wr & (req.idx == IDX_MASK);
  wire wrCfg = req.wr & (req.idx == IDX_CFG);
  wire wrMaster = req.wr & (req.idx == IDX_MASTER);
  wire rdStatus = req.rd & (req.idx == IDX_STATUS);

  // read data selection, unmapped reads as zero
  assign rdData = (req.idx == IDX_MASK) ? mask_r :
                  (req.idx == IDX_STATUS) ? status_r :
                  (req.idx == IDX_CFG) ? cfg_r :
                  (req.idx == IDX_MASTER) ? master_r :
                  16'h0000;

  // mask: plain read-write enables
  assign mask_nxt = wrMask ? req.wdata : mask_r;

  // master control: bit 0 gates all interrupts
  assign master_nxt = wrMaster ? {15'h0000, req.wdata[MASTER_EN_POS]} : master_r;

  // per-bit status update
  for (genvar b = 0; b < REG_W; b++) begin : g_stat
    if (LIVE_BITS[b]) begin : g_live
      // read-only level, not cleared by reading
      assign status_nxt[b] = eventIn[b];
    end else begin : g_latch
      // set wins over the read clear
      assign status_nxt[b] = eventIn[b] | (status_r[b] & ~rdStatus);
    end
  end

  // configuration write value, soft reset bit never stored
  always_comb begin
    cfgWr = pecfg_cfg_t'(req.wdata);
    cfgWr.serialMacSoftReset = 1'b0;
  end

  // configuration next value
  always_comb begin
    cfg_nxt = wrCfg ? cfgWr : cfg_r;
    // hardware ends the probe unless software sets it now
    if (pdProbeDone && !(wrCfg && req.wdata[CFG_PD_POS])) begin
      cfg_nxt.poweredDeviceProbeEnable = 1'b0;
    end
  end

  // gated interrupt request
  wire intRaw = master_r[MASTER_EN_POS] & (|(status_r & mask_r));

  // register file
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= MASK_RST;
      status_r <= STATUS_RST;
      master_r <= MASTER_RST;
      cfg_r <= CFG_RST;
    end else begin
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      master_r <= master_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // pin polarity and soft reset pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intPin_r <= 1'b1;
      srst_r <= 1'b0;
    end else begin
      intPin_r <= intRaw ^ cfg_r.intActiveLow;
      srst_r <= wrCfg & req.wdata[CFG_SRST_POS];
    end
  end

  // decoded downshift attempts and clock enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tries_r <= 4'h4;
      txOn_r <= 1'b1;
    end else begin
      tries_r <= 4'h1 << cfg_r.downshiftTryCount;
      txOn_r <= (cfg_r.txClockSelect == TXCLK_SLOW) | (cfg_r.txClockSelect == TXCLK_FAST);
    end
  end

  assign intPin = intPin_r;
  assign cfgOut = cfg_r;
  assign serialMacReset = srst_r;
  assign downshiftTries = tries_r;
  assign txClockOn = txOn_r;

  // pin stays inactive while nothing enabled is pending
  property p_pin_idle;
    @(posedge clk) disable iff (!rst_n)
      (!master_r[MASTER_EN_POS] || ((status_r & mask_r) == 16'h0000))
        |=> (intPin_r == $past(cfg_r.intActiveLow));
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin active without enabled event");

  // pin asserts at selected level when an enabled event is pending
  property p_pin_active;
    @(posedge clk) disable iff (!rst_n)
      (master_r[MASTER_EN_POS] && ((status_r & mask_r) != 16'h0000))
        |=> (intPin_r == !$past(cfg_r.intActiveLow));
  endproperty
  a_pin_active: assert property (p_pin_active) else $error("pin not active for enabled event");

  // latched event always recorded, even during a read
  property p_event_kept;
    @(posedge clk) disable iff (!rst_n)
      ((eventIn & LATCH_BITS) != 16'h0000)
        |=> ((status_r & $past(eventIn & LATCH_BITS)) == $past(eventIn & LATCH_BITS));
  endproperty
  a_event_kept: assert property (p_event_kept) else $error("event lost");

  // latched bits hold while not read
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !rdStatus |=> ((status_r & $past(status_r & LATCH_BITS)) == $past(status_r & LATCH_BITS));
  endproperty
  a_hold: assert property (p_hold) else $error("latched status dropped without read");

  // a read with no new event clears latched bits
  property p_read_clear;
    @(posedge clk) disable iff (!rst_n)
      (rdStatus && ((eventIn & LATCH_BITS) == 16'h0000)) |=> ((status_r & LATCH_BITS) == 16'h0000);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

  // read-only bits follow their source
  property p_live;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> ((status_r & LIVE_BITS) == ($past(eventIn) & LIVE_BITS));
  endproperty
  a_live: assert property (p_live) else $error("read-only status mismatch");

  // mask takes written value
  property p_mask_write;
    @(posedge clk) disable iff (!rst_n)
      wrMask |=> (mask_r == $past(req.wdata));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // soft reset is a single pulse and the bit reads zero
  property p_srst_pulse;
    @(posedge clk) disable iff (!rst_n)
      (wrCfg && req.wdata[CFG_SRST_POS]) |=> (srst_r && !cfg_r.serialMacSoftReset) ##1 !srst_r;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse wrong");

  // attempt count decode
  property p_tries;
    @(posedge clk) disable iff (!rst_n)
      $stable(cfg_r.downshiftTryCount) |=> (tries_r == (4'h1 << $past(cfg_r.downshiftTryCount)));
  endproperty
  a_tries: assert property (p_tries) else $error("downshift attempt decode wrong");

  // configuration field stored from write
  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n)
      (wrCfg && !pdProbeDone) |=> (cfg_r[12:0] == {1'b0, $past(req.wdata[11:0])}
        && cfg_r[15:13] == $past(req.wdata[15:13]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write wrong");

  // probe enable cleared by hardware
  property p_pd_clear;
    @(posedge clk) disable iff (!rst_n)
      (pdProbeDone && !wrCfg) |=> !cfg_r.poweredDeviceProbeEnable;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("probe enable not cleared");

  // soft reset pulse only after a write that sets the bit
  property p_srst_only;
    @(posedge clk) disable iff (!rst_n)
      !(wrCfg && req.wdata[CFG_SRST_POS]) |=> !srst_r;
  endproperty
  a_srst_only: assert property (p_srst_only) else $error("soft reset pulse without write");

  // soft reset bit is never stored
  property p_srst_bit_zero;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |-> !cfg_r.serialMacSoftReset;
  endproperty
  a_srst_bit_zero: assert property (p_srst_bit_zero) else $error("soft reset bit stored");

  // transmit clock off for selections two and three
  property p_txclk;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> (txOn_r == !$past(cfg_r.txClockSelect[1]));
  endproperty
  a_txclk: assert property (p_txclk) else $error("transmit clock enable wrong");

  // attempt count is always a single power of two
  property p_tries_onehot;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |-> $onehot(tries_r);
  endproperty
  a_tries_onehot: assert property (p_tries_onehot) else $error("attempt count not one-hot");

  // software set of the probe enable wins over the hardware clear
  property p_pd_sw_wins;
    @(posedge clk) disable iff (!rst_n)
      (wrCfg && req.wdata[CFG_PD_POS]) |=> cfg_r.poweredDeviceProbeEnable;
  endproperty
  a_pd_sw_wins: assert property (p_pd_sw_wins) else $error("probe enable write lost");

  // configuration holds without write or probe clear
  property p_cfg_hold;
    @(posedge clk) disable iff (!rst_n)
      (!wrCfg && !pdProbeDone) |=> (cfg_r == $past(cfg_r));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

  // mask holds without write
  property p_mask_hold;
    @(posedge clk) disable iff (!rst_n)
      !wrMask |=> (mask_r == $past(mask_r));
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  // latched bit rises only after its event
  property p_no_spurious;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> ((status_r & LATCH_BITS & ~$past(status_r | eventIn)) == 16'h0000);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("latched status rose without event");

  // master enable follows its write
  property p_master_write;
    @(posedge clk) disable iff (!rst_n)
      wrMaster |=> (master_r[MASTER_EN_POS] == $past(req.wdata[MASTER_EN_POS]));
  endproperty
  a_master_write: assert property (p_master_write) else $error("master enable write lost");

  // master control holds without write
  property p_master_hold;
    @(posedge clk) disable iff (!rst_n)
      !wrMaster |=> (master_r == $past(master_r));
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("master control changed without write");

  // pin idle while every enable is clear
  property p_mask_zero_idle;
    @(posedge clk) disable iff (!rst_n)
      (mask_r == 16'h0000) |=> (intPin_r == $past(cfg_r.intActiveLow));
  endproperty
  a_mask_zero_idle: assert property (p_mask_zero_idle) else $error("pin active with empty mask");

  // active-high pin rests low while interrupts are off
  property p_pol_high;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_r.intActiveLow && !master_r[MASTER_EN_POS]) |=> !intPin_r;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("active-high pin not resting low");

  // active-low pin rests high while interrupts are off
  property p_pol_low;
    @(posedge clk) disable iff (!rst_n)
      (cfg_r.intActiveLow && !master_r[MASTER_EN_POS]) |=> intPin_r;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("active-low pin not resting high");

  // status read returns the latched value, upper half zero
  property p_rd_status;
    @(posedge clk) disable iff (!rst_n)
      rdStatus |=> (hrdata == {16'h0000, $past(status_r)});
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read data wrong");

  // mask read returns the stored enables
  property p_rd_mask;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && (req.idx == IDX_MASK)) |=> (hrdata == {16'h0000, $past(mask_r)});
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask read data wrong");

  // configuration read returns the stored fields
  property p_rd_cfg;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && (req.idx == IDX_CFG)) |=> (hrdata == {16'h0000, $past(cfg_r)});
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read data wrong");
endmodule : pecfg_top

// *** verification/pecfg_event_src.sv ***
/*
  event source model: turns bench requests into event inputs.
  assumes the bench changes its requests right after a rising edge.
*/
`timescale 1ns/1ps
module pecfg_event_src import pecfg_pkg::*; (
  // bench requests
  input wire logic [15:0] pulseReq,
  input wire logic [15:0] levelReq,
  input wire logic probeReq,
  // toward the block
  output logic [15:0] eventIn,
  output logic pdProbeDone
);
  // latched kinds come as pulses, live kinds as levels
  assign eventIn = (pulseReq & LATCH_BITS) | (levelReq & LIVE_BITS);
  // hardware clear of the probe enable
  assign pdProbeDone = probeReq;
endmodule : pecfg_event_src

// *** verification/testbench.sv ***
/*
  self-checking bench: ahb-lite master tasks and one task per scenario.
  assumes pecfg_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
module testbench import pecfg_pkg::*; ();
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic probeReq = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] pulseReq = 16'h0;
  logic [15:0] levelReq = 16'h0;
  logic hreadyout, hresp, intPin, serialMacReset, txClockOn, pdProbeDone;
  logic [31:0] hrdata, rd;
  logic [15:0] eventIn;
  logic [3:0] downshiftTries;
  pecfg_cfg_t cfgOut;
  int numErrors = 0;
  int checked = 0;
  int srCount = 0;
  localparam logic [31:0] A_MASK = {22'h0, IDX_MASK, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, IDX_STATUS, 2'h0};
  localparam logic [31:0] A_CFG = {22'h0, IDX_CFG, 2'h0};
  localparam logic [31:0] A_MSTR = {22'h0, IDX_MASTER, 2'h0};
  localparam logic [31:0] A_NONE = 32'h0000_0100;

  // block and event model
  pecfg_top pecfg_top_inst (.clk(clk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .eventIn(eventIn), .pdProbeDone(pdProbeDone), .intPin(intPin),
    .cfgOut(cfgOut), .serialMacReset(serialMacReset), .downshiftTries(downshiftTries), .txClockOn(txClockOn));
  pecfg_event_src pecfg_event_src_inst (.pulseReq(pulseReq), .levelReq(levelReq), .probeReq(probeReq),
    .eventIn(eventIn), .pdProbeDone(pdProbeDone));

  // clock, 25 ns period
  initial begin
    forever #12.5 clk = ~clk;
  end

  // counts soft reset pulses
  always @(posedge clk) begin
    if (serialMacReset === 1'b1) srCount <= srCount + 1;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one single transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    r = hrdata;
    cmp(hresp, 1'b0);
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    cmp(rd, e);
  endtask : rchk

  // one-cycle event, then time for status and pin to settle
  task automatic ev(input logic [15:0] b);
    pulseReq <= b;
    @(posedge clk);
    pulseReq <= 16'h0;
    repeat (3) @(posedge clk);
  endtask : ev

  task automatic t_reset();
    rchk(A_MASK, 32'h0);
    rchk(A_STAT, 32'h0);
    rchk(A_CFG, 32'h29C7);
    cmp(intPin, 1'b1);
    cmp(downshiftTries, 4'h4);
    cmp(txClockOn, 1'b1);
    wr(A_NONE, 32'hFFFF);
    rchk(A_NONE, 32'h0);
    wr(A_MASK, 32'hA5A5);
    rchk(A_MASK, 32'hA5A5);
    wr(A_MASK, 32'h0);
  endtask : t_reset

  task automatic t_status();
    ev(LATCH_BITS);
    wr(A_STAT, 32'h0);
    rchk(A_STAT, {16'h0, LATCH_BITS});
    rchk(A_STAT, 32'h0);
    levelReq <= LIVE_BITS;
    repeat (2) @(posedge clk);
    rchk(A_STAT, {16'h0, LIVE_BITS});
    rchk(A_STAT, {16'h0, LIVE_BITS});
    levelReq <= 16'h0;
    repeat (2) @(posedge clk);
    rchk(A_STAT, 32'h0);
    pulseReq <= 16'h0001;
    xfer(1'b0, A_STAT, 32'h0, rd);
    pulseReq <= 16'h0;
    cmp(rd, 32'h1);
    rchk(A_STAT, 32'h1);
    rchk(A_STAT, 32'h0);
  endtask : t_status

  task automatic t_irq();
    wr(A_MSTR, 32'h1);
    wr(A_MASK, 32'h8000);
    ev(16'h4000);
    cmp(intPin, 1'b1);
    ev(16'h8000);
    cmp(intPin, 1'b0);
    rchk(A_STAT, 32'hC000);
    repeat (2) @(posedge clk);
    cmp(intPin, 1'b1);
    wr(A_MSTR, 32'h0);
    ev(16'h8000);
    cmp(intPin, 1'b1);
    wr(A_CFG, 32'h09C7);
    repeat (2) @(posedge clk);
    cmp(intPin, 1'b0);
    wr(A_MSTR, 32'h1);
    repeat (2) @(posedge clk);
    cmp(intPin, 1'b1);
    rchk(A_STAT, 32'h8000);
    wr(A_MSTR, 32'h0);
    wr(A_MASK, 32'h0);
    wr(A_CFG, 32'h29C7);
  endtask : t_irq

  task automatic t_cfg();
    logic [15:0] w;
    int n0;
    for (int k = 0; k < 4; k++) begin
      w = 16'h6000 | (16'(k) << 10) | (16'(k) << 4) | ((k % 2) ? 16'h03CF : 16'h0000);
      wr(A_CFG, {16'h0, w});
      repeat (2) @(posedge clk);
      cmp(cfgOut, w);
      cmp(downshiftTries, 4'h1 << k);
      cmp(txClockOn, k < 2);
      rchk(A_CFG, {16'h0, w});
    end
    n0 = srCount;
    wr(A_CFG, 32'h39C7);
    repeat (3) @(posedge clk);
    cmp(srCount - n0, 32'h1);
    rchk(A_CFG, 32'h29C7);
    wr(A_CFG, 32'hA9C7);
    rchk(A_CFG, 32'hA9C7);
    probeReq <= 1'b1;
    @(posedge clk);
    probeReq <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(A_CFG, 32'h29C7);
  endtask : t_cfg

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    t_reset();
    t_status();
    t_irq();
    t_cfg();
    end_sim();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    end_sim();
  end
endmodule : testbench
